/* pkg/tdc_map.vh */
`ifndef TDC_MAP_VH
`define TDC_MAP_VH

`define TDC_AW              4
`define TDC_DW              16
`define TDC_SW              8
`define TDC_LW              13
`define TDC_NCH             4

`define TDC_OFF_BIN_THR     4'h3
`define TDC_OFF_WA_THR      4'h4
`define TDC_OFF_WB_THR      4'h5
`define TDC_OFF_WC_THR      4'h6
`define TDC_OFF_BIN_CFG     4'h7
`define TDC_OFF_WA_CFG      4'h8
`define TDC_OFF_WB_CFG      4'h9
`define TDC_OFF_WC_CFG      4'hA

`define TDC_RST_BIN_THR     16'h5AAA
`define TDC_RST_WA_THR      16'hCCCC
`define TDC_RST_WB_THR      16'h5A88
`define TDC_RST_WC_THR      16'h2D2D
`define TDC_RST_BIN_CFG     16'h0096
`define TDC_RST_W_CFG       16'h80FA

`define TDC_HI_MSB          7
`define TDC_HI_LSB          0
`define TDC_LO_MSB          15
`define TDC_LO_LSB          8
`define TDC_EN_BIT          15
`define TDC_MODE_BIT        14
`define TDC_LEN_MSB         12
`define TDC_LEN_LSB         0
`define TDC_CFG_WMASK       16'hDFFF

`define TDC_TICK_NS         20000
`define TDC_CLK_NS          8
`define TDC_TICK_CYC        (`TDC_TICK_NS / `TDC_CLK_NS)
`define TDC_TICK_W          12

`endif

/* rtl/tdc_channels.v */
// Operation
// - Comparator sets when sample is strictly above high level bits [7:0].
// - Comparator clears when sample is at or below low level bits [15:8].
// - Warning A threshold resets to 0xCCCC.
// - Warning B threshold resets to 0x5A88.
// - Warning C threshold resets to 0x2D2D.
// - Binary enable bit 15 low forces binary comparator low; resets to zero.
// - Config bit 14 selects up/down counting; clear means up/clear.
// - Filter length bits [12:0] count 20 us ticks.
// - In up/clear mode, glitches shorter than the filter length leave the output unchanged.
// - Zero filter length bypasses the filter with no delay.
// - Binary configuration resets to 0x0096.
// - Warning C configuration resets to 0x80FA.
// - Warning A configuration resets to 0x80FA with enable, mode, length.
// - Warning B configuration resets to 0x80FA with the same fields.
// - Filtered binary result drives the digital output pin, gated by enable.
`include "tdc_map.vh"

module tdc_channels (
  input  wire                 mclk_i,
  input  wire                 rst_i,
  input  wire                 ce_i,
  input  wire                 smp_vld_i,
  input  wire [`TDC_SW-1:0]   sample_i,
  input  wire                 reg_wr_i,
  input  wire                 reg_rd_i,
  input  wire [`TDC_AW-1:0]   reg_addr_i,
  input  wire [`TDC_DW-1:0]   reg_wdata_i,
  output reg  [`TDC_DW-1:0]   reg_rdata_o,
  output reg                  reg_err_o,
  output reg                  digital_output_pin_o,
  output reg                  warning_a_channel_o,
  output reg                  warning_b_channel_o,
  output reg                  warning_c_channel_o
);
  reg  [`TDC_DW-1:0]     thr_q [0:`TDC_NCH-1];
  reg  [`TDC_DW-1:0]     cfg_q [0:`TDC_NCH-1];
  reg  [`TDC_TICK_W-1:0] tick_cnt_q;
  reg                    tick_q;
  wire [`TDC_NCH-1:0]    cmp_w;
  wire [`TDC_NCH-1:0]    flt_w;

  // 20 us time base shared by all filters
  always @(posedge mclk_i) begin
    if (rst_i) begin
      tick_cnt_q <= {`TDC_TICK_W{1'b0}};
      tick_q     <= 1'b0;
    end else if (ce_i) begin
      if (tick_cnt_q == `TDC_TICK_CYC - 1) begin
        tick_cnt_q <= {`TDC_TICK_W{1'b0}};
        tick_q     <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
        tick_q     <= 1'b0;
      end
    end
  end

  // Register writes; reserved bit 13 of config stays zero
  always @(posedge mclk_i) begin
    if (rst_i) begin
      thr_q[0] <= `TDC_RST_BIN_THR;
      thr_q[1] <= `TDC_RST_WA_THR;
      thr_q[2] <= `TDC_RST_WB_THR;
      thr_q[3] <= `TDC_RST_WC_THR;
      cfg_q[0] <= `TDC_RST_BIN_CFG;
      cfg_q[1] <= `TDC_RST_W_CFG;
      cfg_q[2] <= `TDC_RST_W_CFG;
      cfg_q[3] <= `TDC_RST_W_CFG;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == `TDC_OFF_BIN_THR) begin
        thr_q[0] <= reg_wdata_i;
      end else if (reg_addr_i == `TDC_OFF_WA_THR) begin
        thr_q[1] <= reg_wdata_i;
      end else if (reg_addr_i == `TDC_OFF_WB_THR) begin
        thr_q[2] <= reg_wdata_i;
      end else if (reg_addr_i == `TDC_OFF_WC_THR) begin
        thr_q[3] <= reg_wdata_i;
      end else if (reg_addr_i == `TDC_OFF_BIN_CFG) begin
        cfg_q[0] <= reg_wdata_i & `TDC_CFG_WMASK;
      end else if (reg_addr_i == `TDC_OFF_WA_CFG) begin
        cfg_q[1] <= reg_wdata_i & `TDC_CFG_WMASK;
      end else if (reg_addr_i == `TDC_OFF_WB_CFG) begin
        cfg_q[2] <= reg_wdata_i & `TDC_CFG_WMASK;
      end else if (reg_addr_i == `TDC_OFF_WC_CFG) begin
        cfg_q[3] <= reg_wdata_i & `TDC_CFG_WMASK;
      end
    end
  end

  // Registered read port; unmapped address reads zero and flags error
  always @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= {`TDC_DW{1'b0}};
      reg_err_o   <= 1'b0;
    end else if (ce_i) begin
      reg_err_o <= 1'b0;
      if (reg_rd_i) begin
        if (reg_addr_i == `TDC_OFF_BIN_THR) begin
          reg_rdata_o <= thr_q[0];
        end else if (reg_addr_i == `TDC_OFF_WA_THR) begin
          reg_rdata_o <= thr_q[1];
        end else if (reg_addr_i == `TDC_OFF_WB_THR) begin
          reg_rdata_o <= thr_q[2];
        end else if (reg_addr_i == `TDC_OFF_WC_THR) begin
          reg_rdata_o <= thr_q[3];
        end else if (reg_addr_i == `TDC_OFF_BIN_CFG) begin
          reg_rdata_o <= cfg_q[0];
        end else if (reg_addr_i == `TDC_OFF_WA_CFG) begin
          reg_rdata_o <= cfg_q[1];
        end else if (reg_addr_i == `TDC_OFF_WB_CFG) begin
          reg_rdata_o <= cfg_q[2];
        end else if (reg_addr_i == `TDC_OFF_WC_CFG) begin
          reg_rdata_o <= cfg_q[3];
        end else begin
          reg_rdata_o <= {`TDC_DW{1'b0}};
          reg_err_o   <= 1'b1;
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < `TDC_NCH; g = g + 1) begin : g_ch
      tdc_compare u_cmp (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .ce_i      (ce_i),
        .smp_vld_i (smp_vld_i),
        .sample_i  (sample_i),
        .thr_i     (thr_q[g]),
        .en_i      (cfg_q[g][`TDC_EN_BIT]),
        .cmp_o     (cmp_w[g])
      );
      tdc_debounce u_flt (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .tick_i (tick_q),
        .in_i   (cmp_w[g]),
        .mode_i (cfg_q[g][`TDC_MODE_BIT]),
        .len_i  (cfg_q[g][`TDC_LEN_MSB:`TDC_LEN_LSB]),
        .out_o  (flt_w[g])
      );
    end
  endgenerate

  always @(posedge mclk_i) begin
    if (rst_i) begin
      digital_output_pin_o <= 1'b0;
      warning_a_channel_o  <= 1'b0;
      warning_b_channel_o  <= 1'b0;
      warning_c_channel_o  <= 1'b0;
    end else if (ce_i) begin
      digital_output_pin_o <= flt_w[0] & cfg_q[0][`TDC_EN_BIT];
      warning_a_channel_o  <= flt_w[1];
      warning_b_channel_o  <= flt_w[2];
      warning_c_channel_o  <= flt_w[3];
    end
  end
endmodule

/* rtl/tdc_compare.v */
`include "tdc_map.vh"

module tdc_compare (
  input  wire                 mclk_i,
  input  wire                 rst_i,
  input  wire                 ce_i,
  input  wire                 smp_vld_i,
  input  wire [`TDC_SW-1:0]   sample_i,
  input  wire [`TDC_DW-1:0]   thr_i,
  input  wire                 en_i,
  output reg                  cmp_o
);
  wire [`TDC_SW-1:0] hi_lvl = thr_i[`TDC_HI_MSB:`TDC_HI_LSB];
  wire [`TDC_SW-1:0] lo_lvl = thr_i[`TDC_LO_MSB:`TDC_LO_LSB];

  always @(posedge mclk_i) begin
    if (rst_i) begin
      cmp_o <= 1'b0;
    end else if (ce_i) begin
      if (!en_i) begin
        cmp_o <= 1'b0;
      end else if (smp_vld_i) begin
        if (sample_i > hi_lvl) begin
          cmp_o <= 1'b1;
        end else if (sample_i <= lo_lvl) begin
          cmp_o <= 1'b0;
        end
      end                               // Between levels: hold
    end
  end
endmodule

/* rtl/tdc_debounce.v */
`include "tdc_map.vh"

module tdc_debounce (
  input  wire                 mclk_i,
  input  wire                 rst_i,
  input  wire                 ce_i,
  input  wire                 tick_i,
  input  wire                 in_i,
  input  wire                 mode_i,
  input  wire [`TDC_LW-1:0]   len_i,
  output wire                 out_o
);
  reg               state_q;
  reg [`TDC_LW-1:0] cnt_q;

  // Zero length passes the input straight through
  assign out_o = (len_i == {`TDC_LW{1'b0}}) ? in_i : state_q;

  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= 1'b0;
      cnt_q   <= {`TDC_LW{1'b0}};
    end else if (ce_i) begin
      if (len_i == {`TDC_LW{1'b0}}) begin
        state_q <= in_i;
        cnt_q   <= {`TDC_LW{1'b0}};
      end else if (in_i == state_q) begin
        if (mode_i) begin
          if (tick_i && cnt_q != {`TDC_LW{1'b0}}) begin
            cnt_q <= cnt_q - 1'b1;
          end
        end else begin
          cnt_q <= {`TDC_LW{1'b0}};
        end
      end else if (tick_i) begin
        // Output moves only after len ticks of disagreement
        if (cnt_q + 1'b1 >= len_i) begin
          state_q <= in_i;
          cnt_q   <= {`TDC_LW{1'b0}};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule

/* verification/tdc_adc_model.sv */
module tdc_adc_model #(
  parameter int PERIOD = 4
) (
  input  logic       mclk_i,
  input  logic [7:0] level_i,
  output logic       smp_vld_o,
  output logic [7:0] sample_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    smp_vld_o = 0;
    sample_o = 8'h00;
  end
  // Between samples the data lines carry junk, not the last sample
  always @(posedge mclk_i) begin
    #1;
    cnt = (cnt + 1) % PERIOD;
    smp_vld_o = (cnt == 0);
    sample_o = smp_vld_o ? level_i : ~sample_o;
  end
endmodule

/* verification/tdc_chk.sv */
module tdc_chk (
  input logic        mclk_i,
  input logic        rst_i,
  input logic        ce_i,
  input logic        smp_vld_i,
  input logic [7:0]  sample_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [3:0]  reg_addr_i,
  input logic [15:0] reg_wdata_i,
  input logic [15:0] reg_rdata_o,
  input logic        reg_err_o,
  input logic        digital_output_pin_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] thr_q;
  logic [15:0] cfg_q;
  wire         rd  = reg_rd_i && ce_i;
  wire         byp = smp_vld_i && ce_i && cfg_q[15] && cfg_q[12:0] == 13'h0;
  // Shadow of the binary path registers, seen through the write port
  always @(posedge mclk_i) begin
    if (rst_i) begin
      thr_q <= 16'h5AAA;
      cfg_q <= 16'h0096;
    end else if (reg_wr_i && ce_i && reg_addr_i == 4'h3) begin
      thr_q <= reg_wdata_i;
    end else if (reg_wr_i && ce_i && reg_addr_i == 4'h7) begin
      cfg_q <= reg_wdata_i;
    end
  end
  property p_err;
    reg_err_o |-> $past(rd && (reg_addr_i < 4'h3 || reg_addr_i > 4'hA));
  endproperty
  a_err: assert property (p_err) else $error("error flag without unmapped read");
  property p_rst_pin;
    $fell(rst_i) |-> !digital_output_pin_o;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin high after reset");
  property p_bit13;
    $past(rd && reg_addr_i >= 4'h7 && reg_addr_i <= 4'hA) |-> !reg_rdata_o[13];
  endproperty
  a_bit13: assert property (p_bit13) else $error("reserved config bit set");
  property p_hold;
    !$past(rd) && !$past(rst_i) |-> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_freeze;
    !ce_i |=> $stable(digital_output_pin_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("pin moved while frozen");
  property p_dis;
    !cfg_q[15] [*4] |-> !digital_output_pin_o;
  endproperty
  a_dis: assert property (p_dis) else $error("pin high while disabled");
  property p_en;
    $rose(digital_output_pin_o) |-> cfg_q[15];
  endproperty
  a_en: assert property (p_en) else $error("pin rose while disabled");
  property p_hi;
    byp && sample_i > thr_q[7:0] |-> ##2 digital_output_pin_o;
  endproperty
  a_hi: assert property (p_hi) else $error("pin not set above high level");
  property p_lo;
    byp && sample_i <= thr_q[15:8] |-> ##2 !digital_output_pin_o;
  endproperty
  a_lo: assert property (p_lo) else $error("pin not cleared at low level");
endmodule
bind tdc_channels tdc_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
  .smp_vld_i(smp_vld_i), .sample_i(sample_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
  .reg_err_o(reg_err_o), .digital_output_pin_o(digital_output_pin_o));

/* verification/threshold_debounce_channels_tb_top.sv */
module threshold_debounce_channels_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 0, rst_i = 1, ce_i = 1, wr = 0, rd = 0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata, d;
  logic [7:0]  level = 8'h00, sample;
  logic        vld, err, pin, wa, wb, wc, e;
  int          miscompares = 0, samples_checked = 0, cyc = 0;
  logic [15:0] rtab [4:10] = '{16'hCCCC, 16'h5A88, 16'h2D2D, 16'h0096, 16'h80FA, 16'h80FA, 16'h80FA};
  logic [7:0]  lv [5] = '{8'hAB, 8'h80, 8'h5A, 8'hAA, 8'h5B};
  logic        ev [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  always #4 mclk_i = ~mclk_i;
  tdc_adc_model adc (.mclk_i(mclk_i), .level_i(level), .smp_vld_o(vld), .sample_o(sample));
  tdc_channels dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i), .smp_vld_i(vld),
    .sample_i(sample), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_err_o(err), .digital_output_pin_o(pin),
    .warning_a_channel_o(wa), .warning_b_channel_o(wb), .warning_c_channel_o(wc));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] v);
    addr = a;
    wdata = v;
    wr = 1;
    tick(1);
    wr = 0;
    tick(1);
  endtask
  // Data and error flag are taken one edge after the strobe, where they stand
  task automatic rreg(input logic [3:0] a, output logic [15:0] q, output logic f);
    addr = a;
    rd = 1;
    tick(1);
    q = rdata;
    f = err;
    rd = 0;
    tick(1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    tick(16);
    rst_i = 0;
    for (int a = 4; a <= 10; a++) begin
      rreg(a[3:0], d, e);
      chk("reset value", d, rtab[a]);
    end
    rreg(4'hF, d, e);
    chk("unmapped data", d, 16'h0000);
    chk("unmapped flag", {15'h0, e}, 16'h0001);
    wreg(4'hA, 16'hFFFF);
    rreg(4'hA, d, e);
    chk("read-only bit", d, 16'hDFFF);
    ce_i = 0;
    level = 8'hFF;
    tick(3);
    ce_i = 1;
    tick(12);
    chk("pin disabled", {15'h0, pin}, 16'h0000);
    wreg(4'h7, 16'h8000);
    foreach (lv[i]) begin
      level = lv[i];
      tick(10);
      chk("pin", {15'h0, pin}, {15'h0, ev[i]});
    end
    level = 8'h05;
    wreg(4'h4, 16'h1020);
    wreg(4'h8, 16'h8002);
    tick(10);
    level = 8'h30;
    tick(2400);
    chk("warn a early", {15'h0, wa}, 16'h0000);
    tick(5200);
    chk("warn a late", {15'h0, wa}, 16'h0001);
    level = 8'h05;
    tick(1000);
    level = 8'h30;
    tick(3000);
    chk("warn a glitch", {15'h0, wa}, 16'h0001);
    level = 8'h05;
    tick(7600);
    chk("warn a low", {15'h0, wa}, 16'h0000);
    wreg(4'h5, 16'h1020);
    wreg(4'h8, 16'h8003);
    wreg(4'h9, 16'hC003);
    repeat (4) begin
      level = 8'h30;
      tick(5000);
      level = 8'h05;
      tick(2500);
    end
    chk("warn a up clear", {15'h0, wa}, 16'h0000);
    chk("warn b up down", {15'h0, wb}, 16'h0001);
    chk("warn c low", {15'h0, wc}, 16'h0000);
    wreg(4'hA, 16'h8000);
    level = 8'h30;
    tick(10);
    chk("warn c bypass", {15'h0, wc}, 16'h0001);
    results();
  end
endmodule
